// [core/chan_pkg.sv]
// package: shared types and constants of the selector channel control block
package chan_pkg;

    // ************************************************************
    // control word bit positions (write and readback)
    // ************************************************************
    localparam int CTL_HW_XFER = 0;
    localparam int CTL_INPUT = 1;
    localparam int CTL_DIAG = 2;
    localparam int CTL_CHAIN = 3;
    localparam int STS_INTERLOCK = 4;
    localparam int STS_PARITY = 5;
    localparam int STS_EARLY = 6;
    localparam int CTL_PACK = 7;
    localparam int STS_RETRY = 8;
    localparam int STS_PACK_OPT = 15;

    // ************************************************************
    // widths, reset values and buffer shape
    // ************************************************************
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // tag lines from adapters and control units
    typedef struct packed {
        logic retry_request_in;
        logic disconnect_in;
        logic data_in;
        logic request_in;
        logic select_in;
        logic operational_in;
        logic service_in;
        logic status_in;
        logic address_in;
    } tag_in_type;

    // tag-out lines as held in the tag-out register
    typedef struct packed {
        logic data_out;
        logic suppress_out;
        logic operational_out;
        logic service_out;
        logic command_out;
        logic address_out;
    } tag_out_type;

    // processor register access strobes
    typedef struct packed {
        logic write_pulse;
        logic read_pulse;
        logic select_line_one;
        logic select_line_two;
        logic select_line_three;
    } reg_access_type;

endpackage : chan_pkg

// [core/channel_control_status_and_byte_count.sv]
// selector channel control register, status flags, byte counter and input buffer
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// input buffer
// ************************************************************
module chan_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    always_comb begin
        in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid = wr_q != rd_q;
        out_data = mem_q[rd_q[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge ref_clk) begin
        wr_q <= rst ? '0 : wr_d;
        rd_q <= rst ? '0 : rd_d;
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule : chan_fifo

// Summary of operation
// R1 - hardware transfer bit enables byte handling, storage requests
// R2 - bypass flag merges ranks; cleared by transfer
// R3 - direction bit set selects input, clear output
// R4 - software sets direction before input transfer
// R5 - diagnostic loops output rank onto tag lines
// R6 - data chaining keeps transfer bit across exit
// R7 - packing bit selects two-byte storage transfers
// R8 - select two high, three low reads status
// R9 - readback layout: control, errors, retry, option bit
// R10 - conflicting inbound tags set interlock error
// R11 - command-out with service/data-out sets interlock
// R12 - channel clear resets flags, transfer and chain bits
// R13 - parity flag clocked per byte, not adapters
// R14 - disconnect, command-out, service-out, clear drop parity
// R15 - stop after count exhaustion sets early flag
// R16 - early flag and count report termination kind
// R17 - sixteen-bit up counter loads complement on write
// R18 - software writes byte count minus one
// R19 - counter increments on service/data-out trailing edge
// R20 - carry clears direction, packing; raises command-out
// R21 - select two and three high read counter
// R22 - select three alone reads eight tag lines
// R23 - inbound tags synchronised before use
module channel_control_status_and_byte_count (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // processor register access
    input wire chan_pkg::reg_access_type reg_access,
    input wire logic [15:0] proc_output_lines,
    output logic [15:0] proc_input_lines,
    input wire logic io_exit_pulse,
    // tag lines
    input wire chan_pkg::tag_in_type tag_in,
    input wire chan_pkg::tag_out_type tag_out_reg,
    output logic command_out_drive,
    output logic service_out_drive,
    output logic data_out_drive,
    output logic [7:0] tag_in_loopback,
    output logic tag_in_loopback_en,
    // bus in and bus out data
    input wire logic [7:0] bus_in_data,
    input wire logic bus_in_parity,
    input wire logic adapter_selected,
    input wire logic disconnect_seq_pulse,
    input wire logic rank_gate_pulse,
    output logic [7:0] bus_out_data,
    output logic bus_out_parity,
    // storage side
    output logic storage_rd_valid,
    input wire logic storage_rd_ready,
    output logic [15:0] storage_rd_data,
    input wire logic storage_wr_valid,
    output logic storage_wr_ready,
    input wire logic [15:0] storage_wr_data,
    // option strap
    input wire logic packing_option_present
);
    import chan_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic hw_transfer_ctl_q, hw_transfer_ctl_d, rank_bypass_flag_q, rank_bypass_flag_d;
    logic input_dir_q, input_dir_d, diag_q, diag_d, chain_q, chain_d;
    logic packing_mode_bit_q, packing_mode_bit_d, resp_q, resp_d;
    logic interlock_err_q, interlock_err_d, parity_err_q, parity_err_d;
    logic early_stop_flag_q, early_stop_flag_d, cmd_stop_q, cmd_stop_d;
    logic [15:0] transfer_byte_counter_q, transfer_byte_counter_d;
    logic [15:0] proc_input_lines_q, proc_input_lines_d, output_data_reg_q, output_data_reg_d;
    logic [7:0] input_rank_one_q, input_rank_one_d, even_byte_q, even_byte_d;
    logic [7:0] output_rank_two_q, output_rank_two_d;
    logic odd_byte_q, odd_byte_d, rank_full_q, rank_full_d, out_full_q, out_full_d;
    logic out_odd_q, out_odd_d, svc_dat_prev_q, tor_stop_srv_q;
    tag_in_type sync1_q, sync2_q, sync3_q;
    logic channel_clear, diag_loop, eff_cmd, eff_srv, eff_dat, svc_dat;
    logic in_rise, in_fall, out_trail, carry, counter_load_pulse, ctl_write;
    logic byte_strobe, fifo_in_valid, fifo_in_ready;
    logic [15:0] fifo_in_data, status_word;
    logic [7:0] rank_one_src;
    logic two_inbound;

    // ************************************************************
    // tag synchronisers
    // ************************************************************
    // R23 tag synchronisation
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {sync1_q, sync2_q, sync3_q, svc_dat_prev_q, tor_stop_srv_q} <= '0;
        end else begin
            {sync1_q, sync2_q, sync3_q} <= {tag_in, sync1_q, sync2_q};
            svc_dat_prev_q <= svc_dat;
            tor_stop_srv_q <= tag_out_reg.command_out || tag_out_reg.service_out;
        end
    end

    // ************************************************************
    // decode and combinational terms
    // ************************************************************
    always_comb begin
        // R12 channel clear
        channel_clear = !tag_out_reg.operational_out && !diag_q;
        // R5 diagnostic loopback
        diag_loop = diag_q && !tag_out_reg.operational_out && !tag_out_reg.suppress_out;
        eff_cmd = tag_out_reg.command_out || cmd_stop_q;
        eff_srv = tag_out_reg.service_out || (resp_q && sync2_q.service_in);
        eff_dat = tag_out_reg.data_out || (resp_q && sync2_q.data_in && !sync2_q.service_in);
        svc_dat = eff_srv || eff_dat;
        in_rise = (sync2_q.service_in && !sync3_q.service_in)
            || (sync2_q.data_in && !sync3_q.data_in);
        in_fall = !(sync2_q.service_in || sync2_q.data_in);
        out_trail = svc_dat_prev_q && !svc_dat;
        // R17 counter load strobe
        counter_load_pulse = reg_access.write_pulse && reg_access.select_line_one;
        ctl_write = reg_access.write_pulse && reg_access.select_line_two
            && !reg_access.select_line_three;
        // R20 carry out of the top bit
        carry = hw_transfer_ctl_q && out_trail
            && transfer_byte_counter_q == COUNT_ALL_ONES;
        two_inbound = (32'(sync2_q.address_in) + 32'(sync2_q.status_in)
            + 32'(sync2_q.service_in || sync2_q.data_in)) >= 32'd2;
        rank_one_src = diag_loop ? output_rank_two_q : bus_in_data;
        // R3 input gating only when direction is input
        byte_strobe = hw_transfer_ctl_q && input_dir_q && in_rise && !cmd_stop_q
            && !rank_full_q;
        // R9 readback layout
        status_word = WORD_ZERO;
        status_word[CTL_HW_XFER] = hw_transfer_ctl_q;
        status_word[CTL_INPUT] = input_dir_q;
        status_word[CTL_DIAG] = diag_q;
        status_word[CTL_CHAIN] = chain_q;
        status_word[STS_INTERLOCK] = interlock_err_q;
        status_word[STS_PARITY] = parity_err_q;
        // R16 early flag with the count tells who stopped
        status_word[STS_EARLY] = early_stop_flag_q;
        status_word[CTL_PACK] = packing_mode_bit_q;
        status_word[STS_RETRY] = sync2_q.retry_request_in;
        status_word[STS_PACK_OPT] = packing_option_present;
    end

    always_comb begin
        {hw_transfer_ctl_d, rank_bypass_flag_d, input_dir_d, diag_d, chain_d} =
            {hw_transfer_ctl_q, rank_bypass_flag_q, input_dir_q, diag_q, chain_q};
        {packing_mode_bit_d, interlock_err_d, parity_err_d, early_stop_flag_d, cmd_stop_d} =
            {packing_mode_bit_q, interlock_err_q, parity_err_q, early_stop_flag_q, cmd_stop_q};
        if (ctl_write) begin
            hw_transfer_ctl_d = proc_output_lines[CTL_HW_XFER];
            // R2 bypass cleared when transfer bit written set
            rank_bypass_flag_d = !proc_output_lines[CTL_HW_XFER];
            input_dir_d = proc_output_lines[CTL_INPUT];
            diag_d = proc_output_lines[CTL_DIAG];
            chain_d = proc_output_lines[CTL_CHAIN];
            packing_mode_bit_d = proc_output_lines[CTL_PACK] && packing_option_present;
        end
        // R6 chaining holds the transfer bit
        if (io_exit_pulse && !chain_q) begin
            hw_transfer_ctl_d = 1'b0;
        end
        // R20 carry ends the direction and packing, stops device
        if (carry) begin
            input_dir_d = 1'b0;
            packing_mode_bit_d = 1'b0;
            cmd_stop_d = 1'b1;
        end else if (counter_load_pulse) begin
            cmd_stop_d = 1'b0;
        end
        // R14 preclear as stop or service-out goes active; a byte check below wins
        if (disconnect_seq_pulse || (cmd_stop_d && !cmd_stop_q) || (resp_d && !resp_q)
            || ((tag_out_reg.command_out || tag_out_reg.service_out) && !tor_stop_srv_q)) begin
            parity_err_d = 1'b0;
        end
        // R13 parity clocked per byte, adapters excluded
        if (byte_strobe && !adapter_selected && !diag_loop) begin
            parity_err_d = !(^{bus_in_data, bus_in_parity});
        end
        // R10 inbound tag conflict
        if ((sync2_q.operational_in && sync2_q.select_in) || two_inbound) begin
            interlock_err_d = 1'b1;
        end
        // R11 command-out with service/data-out
        if (eff_cmd && (eff_srv || eff_dat)) begin
            interlock_err_d = 1'b1;
        end
        // R15 stop answered to a service/data request
        if (cmd_stop_q && (sync2_q.service_in || sync2_q.data_in)) begin
            early_stop_flag_d = 1'b1;
        end
        // R12 channel clear resets flags
        if (channel_clear) begin
            hw_transfer_ctl_d = 1'b0;
            rank_bypass_flag_d = 1'b0;
            chain_d = 1'b0;
            interlock_err_d = 1'b0;
            parity_err_d = 1'b0;
            early_stop_flag_d = 1'b0;
            cmd_stop_d = 1'b0;
        end
    end

    always_comb begin
        transfer_byte_counter_d = transfer_byte_counter_q;
        // R17 complement load (R18 count minus one)
        if (counter_load_pulse) begin
            transfer_byte_counter_d = ~proc_output_lines;
        // R19 count on trailing edge
        end else if (hw_transfer_ctl_q && out_trail) begin
            transfer_byte_counter_d = transfer_byte_counter_q + COUNT_ONE;
        end
        proc_input_lines_d = proc_input_lines_q;
        if (reg_access.read_pulse) begin
            unique case ({reg_access.select_line_two, reg_access.select_line_three})
                // R8 status readback
                2'b10: proc_input_lines_d = status_word;
                // R21 counter readback
                2'b11: proc_input_lines_d = transfer_byte_counter_q;
                // R22 eight tag lines
                2'b01: proc_input_lines_d = {BYTE_ZERO, sync2_q[7:0]};
                2'b00: proc_input_lines_d = storage_rd_data;
            endcase
        end
        // R1 answer the adapter after the byte is handled
        resp_d = resp_q;
        if (in_fall || !hw_transfer_ctl_q) begin
            resp_d = 1'b0;
        end else if (in_rise && !cmd_stop_q
            && (input_dir_q ? !rank_full_q : out_full_q)) begin
            resp_d = 1'b1;
        end
        input_rank_one_d = byte_strobe ? rank_one_src : input_rank_one_q;
        // R2 bypass moves rank one straight on, else explicit gate
        fifo_in_valid = rank_full_q && (rank_bypass_flag_q || rank_gate_pulse)
            && !(packing_mode_bit_q && !odd_byte_q);
        // R7 assemble two bytes in packing mode
        fifo_in_data = packing_mode_bit_q ? {input_rank_one_q, even_byte_q}
            : {BYTE_ZERO, input_rank_one_q};
        rank_full_d = byte_strobe || (rank_full_q && !(fifo_in_valid && fifo_in_ready));
        {even_byte_d, odd_byte_d} = {even_byte_q, odd_byte_q};
        if (rank_full_q && packing_mode_bit_q && !odd_byte_q) begin
            even_byte_d = input_rank_one_q;
            odd_byte_d = 1'b1;
            rank_full_d = byte_strobe;
        end else if (fifo_in_valid && fifo_in_ready) begin
            odd_byte_d = 1'b0;
        end
        // output side: one word from storage, split when packing
        storage_wr_ready = !out_full_q && !input_dir_q && hw_transfer_ctl_q;
        {output_data_reg_d, output_rank_two_d} = {output_data_reg_q, output_rank_two_q};
        {out_full_d, out_odd_d} = {out_full_q, out_odd_q};
        if (storage_wr_valid && storage_wr_ready) begin
            output_data_reg_d = storage_wr_data;
            output_rank_two_d = storage_wr_data[7:0];
            out_full_d = 1'b1;
            out_odd_d = packing_mode_bit_q;
        end else if (out_trail && out_full_q && !input_dir_q) begin
            // R7 second byte of a packed word
            if (out_odd_q) begin
                output_rank_two_d = output_data_reg_q[15:8];
                out_odd_d = 1'b0;
            end else begin
                out_full_d = 1'b0;
            end
        end
        if (channel_clear) begin
            out_full_d = 1'b0;
            rank_full_d = 1'b0;
            odd_byte_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {hw_transfer_ctl_q, rank_bypass_flag_q, input_dir_q, diag_q, chain_q,
                packing_mode_bit_q, interlock_err_q, parity_err_q, early_stop_flag_q,
                cmd_stop_q, resp_q, odd_byte_q, rank_full_q, out_full_q, out_odd_q} <= '0;
            {transfer_byte_counter_q, proc_input_lines_q, output_data_reg_q} <=
                {COUNT_RESET, WORD_ZERO, WORD_ZERO};
            {input_rank_one_q, even_byte_q, output_rank_two_q} <= {3{BYTE_ZERO}};
        end else begin
            {hw_transfer_ctl_q, rank_bypass_flag_q, input_dir_q, diag_q, chain_q,
                packing_mode_bit_q, interlock_err_q, parity_err_q, early_stop_flag_q,
                cmd_stop_q, resp_q, odd_byte_q, rank_full_q, out_full_q, out_odd_q} <=
                {hw_transfer_ctl_d, rank_bypass_flag_d, input_dir_d, diag_d, chain_d,
                packing_mode_bit_d, interlock_err_d, parity_err_d, early_stop_flag_d,
                cmd_stop_d, resp_d, odd_byte_d, rank_full_d, out_full_d, out_odd_d};
            {transfer_byte_counter_q, proc_input_lines_q, output_data_reg_q} <=
                {transfer_byte_counter_d, proc_input_lines_d, output_data_reg_d};
            {input_rank_one_q, even_byte_q, output_rank_two_q} <=
                {input_rank_one_d, even_byte_d, output_rank_two_d};
        end
    end

    // R1 storage requests through the buffer
    chan_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst || channel_clear),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(storage_rd_valid),
        .out_ready(storage_rd_ready),
        .out_data(storage_rd_data)
    );

    always_comb begin
        proc_input_lines = proc_input_lines_q;
        command_out_drive = cmd_stop_q;
        service_out_drive = resp_q && sync2_q.service_in;
        data_out_drive = resp_q && sync2_q.data_in && !sync2_q.service_in;
        // R5 loopback onto tag lines and rank one
        tag_in_loopback = output_rank_two_q;
        tag_in_loopback_en = diag_loop;
        bus_out_data = output_rank_two_q;
        // R1 odd parity generated for outbound bytes
        bus_out_parity = !(^output_rank_two_q);
    end
endmodule : channel_control_status_and_byte_count

`default_nettype wire

// [sim/chan_ctl_properties.sv]
// assertion checker for the channel control block
`timescale 1ns/1ps
`default_nettype none
module chan_ctl_properties (
    // clock, reset, register access
    input wire logic ref_clk,
    input wire logic rst,
    input wire chan_pkg::reg_access_type reg_access,
    input wire logic [15:0] proc_output_lines,
    input wire logic [15:0] proc_input_lines,
    // tags and data
    input wire chan_pkg::tag_in_type tag_in,
    input wire chan_pkg::tag_out_type tag_out_reg,
    input wire logic command_out_drive,
    input wire logic service_out_drive,
    input wire logic data_out_drive,
    input wire logic [7:0] bus_out_data,
    input wire logic bus_out_parity,
    input wire logic packing_option_present
);
    import chan_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic s2, logic s3);
        reg_access.read_pulse && reg_access.select_line_two == s2 && reg_access.select_line_three == s3;
    endsequence
    // no byte activity, so the counter cannot move during the load
    sequence s_load;
        reg_access.write_pulse && reg_access.select_line_one && !reg_access.select_line_two
            && !service_out_drive && !data_out_drive;
    endsequence
    property p_stat_rd;
        s_rd(1'b1, 1'b0) |=> proc_input_lines[14:9] == 6'h00
            && proc_input_lines[15] == $past(packing_option_present);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status readback layout wrong");
    property p_tag_rd;
        s_rd(1'b0, 1'b1) |=> proc_input_lines[15:8] == 8'h00;
    endproperty
    a_tag_rd: assert property (p_tag_rd) else $error("tag readback upper byte set");
    property p_cnt_rd;
        s_load ##1 s_rd(1'b1, 1'b1) |=> proc_input_lines == ~$past(proc_output_lines, 2);
    endproperty
    a_cnt_rd: assert property (p_cnt_rd) else $error("counter not loaded complemented");
    property p_stop_hold;
        command_out_drive && tag_out_reg.operational_out
            && !(reg_access.write_pulse && reg_access.select_line_one) |=> command_out_drive;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop flop dropped early");
    property p_no_resp;
        $rose(service_out_drive) |-> !$past(command_out_drive);
    endproperty
    a_no_resp: assert property (p_no_resp) else $error("answer given while stopped");
    property p_resp;
        $rose(service_out_drive) |-> $past(tag_in.service_in || tag_in.data_in, 3)
            || $past(tag_in.service_in || tag_in.data_in, 4);
    endproperty
    a_resp: assert property (p_resp) else $error("answer without synced request");
    property p_par;
        bus_out_parity == ~^bus_out_data;
    endproperty
    a_par: assert property (p_par) else $error("bus out parity not odd");
    property p_rd_stand;
        !reg_access.read_pulse |=> $stable(proc_input_lines);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("readback changed without read");
endmodule : chan_ctl_properties
bind channel_control_status_and_byte_count chan_ctl_properties chk_u (.ref_clk(ref_clk),
    .rst(rst), .reg_access(reg_access), .proc_output_lines(proc_output_lines),
    .proc_input_lines(proc_input_lines), .tag_in(tag_in), .tag_out_reg(tag_out_reg),
    .command_out_drive(command_out_drive), .service_out_drive(service_out_drive),
    .data_out_drive(data_out_drive), .bus_out_data(bus_out_data),
    .bus_out_parity(bus_out_parity), .packing_option_present(packing_option_present));
`default_nettype wire

// [sim/channel_control_status_and_byte_count_tb_top.sv]
// self-checking bench for the channel control block
`timescale 1ns/1ps
`default_nettype none
module channel_control_status_and_byte_count_tb_top;
    import chan_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    reg_access_type ra = '0;
    tag_in_type tags = '0;
    tag_in_type tag_in;
    tag_out_type tor = '0;
    logic [15:0] pol = 16'h0000;
    logic [15:0] pil, rdat;
    logic [8:0] bp = 9'h000;
    logic [7:0] lb, bod, bid;
    logic cmd_d, svc_d, dat_d, lb_en, bpar, svc_in, bip, rv, wr_rdy;
    logic go = 1'b0;
    logic rg = 1'b0;
    logic rdy = 1'b0;
    logic opt = 1'b1;
    int n_mismatch = 0;
    int comparisons = 0;
    always_comb begin
        tag_in = tags;
        tag_in.service_in = svc_in;
    end
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    channel_control_status_and_byte_count dut_u (.ref_clk(ref_clk), .rst(rst),
        .reg_access(ra), .proc_output_lines(pol), .proc_input_lines(pil), .io_exit_pulse(1'b0),
        .tag_in(tag_in), .tag_out_reg(tor), .command_out_drive(cmd_d), .service_out_drive(svc_d),
        .data_out_drive(dat_d), .tag_in_loopback(lb), .tag_in_loopback_en(lb_en),
        .bus_in_data(bid), .bus_in_parity(bip), .adapter_selected(1'b0),
        .disconnect_seq_pulse(1'b0), .rank_gate_pulse(rg), .bus_out_data(bod),
        .bus_out_parity(bpar), .storage_rd_valid(rv), .storage_rd_ready(rdy),
        .storage_rd_data(rdat), .storage_wr_valid(1'b0), .storage_wr_ready(wr_rdy),
        .storage_wr_data(pol), .packing_option_present(opt));
    ctl_unit_model cu_u (.ref_clk(ref_clk), .go(go), .byte_par(bp), .ack(svc_d),
        .service_in(svc_in), .bus_in_data(bid), .bus_in_parity(bip));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [2:0] sel, input logic [15:0] d);
        ra <= {2'b10, sel};
        pol <= d;
        @(posedge ref_clk);
        ra <= '0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [2:0] sel, input logic [15:0] m, input logic [15:0] e);
        ra <= {2'b01, sel};
        @(posedge ref_clk);
        ra <= '0;
        @(posedge ref_clk);
        #1 chk(pil & m, e);
    endtask : rd
    // one inbound byte with odd parity, optionally spoiled
    task automatic send(input logic [7:0] b, input logic bad);
        int k;
        bp <= {~^b ^ bad, b};
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1 k++;
        end while (svc_in && k < 60);
        if (k == 60) begin
            n_mismatch++;
            stop_test();
        end
        rg <= 1'b1;
        @(posedge ref_clk);
        rg <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask : send
    task automatic t_reset();
        rd(3'b010, 16'hffff, 16'h8000);
        rd(3'b011, 16'hffff, 16'h0000);
    endtask : t_reset
    task automatic t_regs();
        tor <= 6'h08;
        wr(3'b010, 16'h008f);
        rd(3'b010, 16'hffff, 16'h808f);
        tags.address_in <= 1'b1;
        tags.retry_request_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(3'b001, 16'hffff, 16'h0001);
        rd(3'b010, 16'h0110, 16'h0100);
        tags.status_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(3'b010, 16'h0010, 16'h0010);
        tags <= '0;
        wr(3'b010, 16'h0000);
        tor <= 6'h00;
        repeat (2) @(posedge ref_clk);
        rd(3'b010, 16'h007f, 16'h0000);
        tor <= 6'h0e;
        repeat (3) @(posedge ref_clk);
        rd(3'b010, 16'h0010, 16'h0010);
    endtask : t_regs
    task automatic t_xfer();
        int k;
        tor <= 6'h08;
        // load three bytes minus one, then read the counter back to back
        ra <= 5'b10100;
        pol <= 16'h0002;
        @(posedge ref_clk);
        ra <= 5'b01011;
        @(posedge ref_clk);
        ra <= '0;
        @(posedge ref_clk);
        #1 chk(pil, 16'hfffd);
        wr(3'b010, 16'h0003);
        send(8'h11, 1'b0);
        send(8'h22, 1'b1);
        rd(3'b010, 16'h0020, 16'h0020);
        rd(3'b011, 16'hffff, 16'hffff);
        send(8'h33, 1'b0);
        chk({15'h0000, cmd_d}, 16'h0001);
        rd(3'b010, 16'h00e3, 16'h0001);
        send(8'h44, 1'b0);
        rd(3'b010, 16'h0040, 16'h0040);
        rd(3'b011, 16'hffff, 16'h0000);
        rdy <= 1'b1;
        for (k = 1; k < 4; k++) begin
            chk({rv, rdat[7:0]}, {1'b1, 8'h11 * k[7:0]});
            @(posedge ref_clk);
            #1;
        end
        rdy <= 1'b0;
        @(posedge ref_clk);
        #1 chk({15'h0000, rv}, 16'h0000);
    endtask : t_xfer
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_regs();
        t_xfer();
        stop_test();
    end
endmodule : channel_control_status_and_byte_count_tb_top
`default_nettype wire

// [sim/ctl_unit_model.sv]
// control unit model: one service-in handshake per request
`timescale 1ns/1ps
`default_nettype none
module ctl_unit_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [8:0] byte_par,
    input wire logic ack,
    output logic service_in,
    output logic [7:0] bus_in_data,
    output logic bus_in_parity
);
    logic [4:0] wait_cnt = 5'h00;
    initial begin
        service_in = 1'b0;
        {bus_in_parity, bus_in_data} = 9'h000;
    end
    // a stopped channel never answers, so give up after a while
    always @(posedge ref_clk) begin
        if (go && !service_in) begin
            {bus_in_parity, bus_in_data} <= byte_par;
            service_in <= 1'b1;
            wait_cnt <= 5'h00;
        end else if (service_in) begin
            wait_cnt <= wait_cnt + 5'h01;
            if (ack || wait_cnt == 5'h1f) begin
                service_in <= 1'b0;
                // released bus must not keep showing the byte
                {bus_in_parity, bus_in_data} <= ~{bus_in_parity, bus_in_data};
            end
        end
    end
endmodule : ctl_unit_model
`default_nettype wire
